/* File: dv/playback_path_and_headset_control_tb.sv */
// Purpose: Self-checking bench for playback and headset control
// Assumes: ref_tick held high, so 1 ms is 1000 cycles
// Notes:   Read results go through a queue to a monitor process
`timescale 1ns/10ps
`default_nettype none

module playback_path_and_headset_control_tb;
   // ==========================================================
   // Signals
   logic                 clk, rst, ref_tick, btn_pin, rd_l;
   logic                 rec_frame_start, play_frame_start, play_sample_tick;
   pph_pkg::pph_req_t    req;
   pph_pkg::pph_stereo_t play_in;
   pph_pkg::pph_hs_t     hs_pin;
   logic [7:0]           rdata, g, ge;
   logic signed [15:0]   play_out;
   logic signed [7:0]    applied_gain;
   logic                 play_muted, dac_power_up, btn_pressed;
   logic                 rec_aux_a, rec_aux_b, play_aux_a, play_aux_b;
   logic                 rec_ic_clear, play_ic_clear;
   logic [1:0]           hs_status;
   logic [31:0]          rng_q;
   logic [15:0]          l, r, e;
   logic [16:0]          sum;
   logic [7:0]           exp_q[$];
   int                   fail_count, n_checks, n;
   localparam logic [7:0] OFS [7] = '{8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42,
                                      8'h43, 8'h50};
   localparam logic [7:0] RSV [7] = '{8'h00, 8'h14, 8'h0C, 8'h00, 8'h00,
                                      8'h00, 8'h00};

   pph_host host (.clk, .req);
   pph_ctrl dut (
      .clk, .rst, .req, .rdata, .ref_tick, .rec_frame_start,
      .play_frame_start, .play_sample_tick, .play_in, .play_out,
      .applied_gain, .play_muted, .dac_power_up, .rec_aux_a, .rec_aux_b,
      .play_aux_a, .play_aux_b, .rec_ic_clear, .play_ic_clear, .hs_pin,
      .btn_pin, .hs_status, .btn_pressed
   );

   always #50 clk = ~clk;

   // ==========================================================
   // Checking
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] ex);
      n_checks++;
      if (seen !== ex) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic rd_exp(input logic [7:0] a, input logic [7:0] ex);
      exp_q.push_back(ex);
      host.rd(a);
   endtask

   always @(posedge clk) rd_l <= req.rd;
   always @(negedge clk) begin
      if (rd_l) chk("rdata", rdata, exp_q.pop_front());
   end

   function automatic logic [31:0] rnd();
      rng_q ^= rng_q << 13;
      rng_q ^= rng_q >> 17;
      rng_q ^= rng_q << 5;
      return rng_q;
   endfunction

   task automatic tick(input logic [15:0] tl, input logic [15:0] tr);
      @(negedge clk);
      play_in = '{left: tl, right: tr};
      play_sample_tick = 1'b1;
      @(negedge clk);
      play_sample_tick = 1'b0;
   endtask

   // Bounded wait on status (sel 0) or button (sel 1)
   task automatic wait_on(input int sel, input logic [1:0] want,
                          input int max);
      n = 0;
      while ((sel == 0 ? hs_status : {1'b0, btn_pressed}) !== want &&
             n < max) begin
         @(negedge clk);
         n++;
      end
      if (n >= max) begin
         fail_count++;
         final_report();
      end
   endtask

   // ==========================================================
   // Sequence
   initial begin
      {clk, rst, ref_tick, btn_pin, rd_l} = 5'h0C;
      {rec_frame_start, play_frame_start, play_sample_tick} = 3'h0;
      play_in = '0;
      hs_pin = '0;
      rng_q = 32'h055FE134;
      repeat (5) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      foreach (OFS[i]) rd_exp(OFS[i], RSV[i]);
      chk("muted", play_muted, 1'b1);
      $display("test reset values done");
      host.wr(8'h3E, 8'h66);
      chk("aux", {rec_aux_a, rec_aux_b, play_aux_a, play_aux_b},
          4'hF);
      for (int h = 0; h < 2; h++) begin
         host.wr(8'h3E, h ? 8'h11 : 8'h00);
         @(negedge clk) {rec_frame_start, play_frame_start} = 2'h3;
         @(negedge clk) {rec_frame_start, play_frame_start} = 2'h0;
         chk("clears", {rec_ic_clear, play_ic_clear},
             h ? 2'h0 : 2'h3);
      end
      $display("test engine bits done");
      host.wr(8'h40, 8'h04);
      for (int c = 0; c < 4; c++) begin
         host.wr(8'h3F, 8'(8'h82 | c << 4));
         tick(16'h0000, 16'h0000);
         l = 16'(rnd());
         r = 16'(rnd());
         sum = {l[15], l} + {r[15], r};
         e = c == 0 ? 16'h0000 : c == 1 ? l : c == 2 ? r : sum[16:1];
         tick(l, r);
         chk("play_out", play_out, e);
      end
      chk("unmuted", play_muted, 1'b0);
      host.wr(8'h3F, 8'h12);
      tick(l, r);
      chk("off_out", play_out, 16'h0000);
      $display("test data path done");
      host.wr(8'h3F, 8'h90);
      host.wr(8'h41, 8'h30);
      repeat (3) tick(l, r);
      chk("gain", applied_gain, 8'h03);
      host.wr(8'h3F, 8'h91);
      repeat (4) tick(l, r);
      chk("gain", applied_gain, 8'h05);
      host.wr(8'h3F, 8'h92);
      for (int i = 0; i < 5; i++) begin
         g = i == 0 ? 8'h81 : 8'(rnd());
         if (g == 8'h80) g = 8'h81;
         ge = (!g[7] && g > 8'h30) ? 8'h30 : g;
         host.wr(8'h41, g);
         tick(l, r);
         chk("gain", $unsigned(applied_gain), ge);
      end
      rd_exp(8'h41, ge);
      host.wr(8'h40, 8'h0C);
      repeat (2) tick(l, r);
      chk("muted", play_muted, 1'b1);
      tick(l, r);
      chk("mute_out", play_out, 16'h0000);
      $display("test gain done");
      for (int k = 0; k < 6; k++) begin
         g = 8'(k << 2 | k[1:0]);
         host.wr(8'h43, 8'h60 | g);
         rd_exp(8'h43, g);
      end
      hs_pin = '{present: 1'b1, mic: 1'b1};
      host.wr(8'h43, 8'h80);
      wait_on(0, 2'h3, 20000);
      chk("ins_time", 16'(n >= 14000 && n <= 18100), 16'h1);
      rd_exp(8'h43, 8'hE0);
      btn_pin = 1'b1;
      wait_on(1, 2'h1, 8);
      host.wr(8'h43, 8'h81);
      btn_pin = 1'b0;
      wait_on(1, 2'h0, 12000);
      chk("btn_time", 16'(n >= 6000), 16'h1);
      hs_pin.mic = 1'b0;
      wait_on(0, 2'h1, 20000);
      host.wr(8'h43, 8'h00);
      wait_on(0, 2'h0, 5);
      $display("test headset done");
      final_report();
   end
endmodule
`default_nettype wire

/* File: dv/pph_ctrl_checker.sv */
// Purpose: Port-level assertions for pph_ctrl
// Assumes: One clock, synchronous active-high reset
// Notes:   Shadows the control bits that the ports do not show
`timescale 1ns/10ps
`default_nettype none

module pph_ctrl_checker (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // Register access
   input wire pph_pkg::pph_req_t  req,
   input wire logic [7:0]         rdata,
   // Strobes
   input wire logic               ref_tick,
   input wire logic               rec_frame_start,
   input wire logic               play_frame_start,
   input wire logic               play_sample_tick,
   // Watched outputs
   input wire logic signed [15:0] play_out,
   input wire logic signed [7:0]  applied_gain,
   input wire logic               play_muted,
   input wire logic               dac_power_up,
   input wire logic               rec_aux_a,
   input wire logic               rec_aux_b,
   input wire logic               play_aux_a,
   input wire logic               play_aux_b,
   input wire logic               rec_ic_clear,
   input wire logic               play_ic_clear,
   input wire logic [1:0]         hs_status,
   input wire logic               btn_pressed
);
   // ==========================================================
   // Shadow state
   logic [1:0] hold_q;
   logic [1:0] step_q;
   logic       hsen_q;
   int         refs_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= 2'h0;
         step_q <= 2'h0;
         hsen_q <= 1'b0;
      end else if (req.wr) begin
         if (req.addr == 8'h3E) hold_q <= {req.wdata[4], req.wdata[0]};
         if (req.addr == 8'h3F) step_q <= req.wdata[1:0];
         if (req.addr == 8'h43) hsen_q <= req.wdata[7];
      end
   end

   // Reference ticks since detection was enabled
   always_ff @(posedge clk) begin
      if (rst || !hsen_q) refs_q <= 0;
      else if (ref_tick) refs_q <= refs_q + 1;
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wr(logic [7:0] a);
      req.wr && req.addr == a;
   endsequence

   sequence s_off;
      !hsen_q [*4];
   endsequence

   a_power_bit: assert property (s_wr(8'h3F) |=>
      dac_power_up == $past(req.wdata[7])) else $error("power bit");
   a_rec_aux: assert property (s_wr(8'h3E) |=>
      {rec_aux_a, rec_aux_b} == $past(req.wdata[6:5])) else $error("rec aux");
   a_play_aux: assert property (s_wr(8'h3E) |=>
      {play_aux_a, play_aux_b} == $past(req.wdata[2:1])) else $error("aux");
   a_rec_clear: assert property (rec_ic_clear ==
      ($past(rec_frame_start) && !$past(hold_q[1]))) else $error("rec clr");
   a_play_clear: assert property (play_ic_clear ==
      ($past(play_frame_start) && !$past(hold_q[0]))) else $error("clr");
   a_off_silent: assert property (play_sample_tick &&
      !dac_power_up |=> play_out == 16'sh0000)
      else $error("powered down output");
   a_mute_silent: assert property (play_sample_tick &&
      play_muted |=> play_out == 16'sh0000) else $error("muted output");
   a_gain_step: assert property (play_sample_tick &&
      step_q == 2'h0 |=>
      8'(applied_gain - $past(applied_gain)) inside {8'h00, 8'h01, 8'hFF})
      else $error("gain step size");
   a_gain_moves: assert property ($changed(applied_gain) |->
      $past(play_sample_tick)) else $error("gain moved without tick");
   a_gain_range: assert property (applied_gain <= 8'sh30 &&
      applied_gain >= 8'sh81) else $error("gain out of range");
   a_stat_code: assert property (hs_status != 2'h2)
      else $error("reserved status");
   a_stat_read: assert property (req.rd && req.addr == 8'h43 |=>
      rdata[6:5] == $past(hs_status)) else $error("status readback");
   a_det_off: assert property (s_off |->
      hs_status == 2'h0 && !btn_pressed) else $error("detect while off");
   a_insert_time: assert property ($rose(hs_status[0]) |->
      refs_q >= 14000) else $error("insertion too fast");
endmodule

bind pph_ctrl pph_ctrl_checker u_chk (
   .clk, .rst, .req, .rdata, .ref_tick, .rec_frame_start, .play_frame_start,
   .play_sample_tick, .play_out, .applied_gain, .play_muted, .dac_power_up,
   .rec_aux_a, .rec_aux_b, .play_aux_a, .play_aux_b, .rec_ic_clear,
   .play_ic_clear, .hs_status, .btn_pressed
);
`default_nettype wire

/* File: dv/pph_host.sv */
// Purpose: Host controller model on the register strobe port
// Assumes: Strobes launched at the falling edge, one cycle wide
// Notes:   Released address and data are inverted, never left stale
`timescale 1ns/10ps
`default_nettype none

module pph_host (
   // Clock
   input  wire logic             clk,
   // Register access
   output var pph_pkg::pph_req_t req
);
   initial req = '0;

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      @(negedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // Host masks reserved bits and caps gain at 0x30, but passes gain code 0x80
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h3F) v[6] = 1'b0;
      if (a == 8'h42) v = 8'h00;
      if (a == 8'h41 && !v[7] && v > 8'h30) v = 8'h30;
      xfer(1'b1, a, v);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 8'h00);
   endtask
endmodule
`default_nettype wire

/* File: hdl/pph_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers on the codec control port
// Notes:   Definitions only
`ifndef PPH_CFG_SVH
`define PPH_CFG_SVH

// ==========================================================
// Register offsets
`define PPH_OFS_MODE        8'h3E
`define PPH_OFS_SETUP       8'h3F
`define PPH_OFS_MUTE        8'h40
`define PPH_OFS_GAIN        8'h41
`define PPH_OFS_RSVD        8'h42
`define PPH_OFS_HSDET       8'h43

// ==========================================================
// Reset values
`define PPH_RST_MODE        8'h00
`define PPH_RST_SETUP       8'h14
`define PPH_RST_MUTE        8'h0C
`define PPH_RST_GAIN        8'h00
`define PPH_RST_RSVD        8'h00
`define PPH_RST_HSDET       8'h00

// ==========================================================
// Field positions
`define PPH_MODE_REC_AUXA   6
`define PPH_MODE_REC_AUXB   5
`define PPH_MODE_REC_HOLD   4
`define PPH_MODE_PLY_AUXA   2
`define PPH_MODE_PLY_AUXB   1
`define PPH_MODE_PLY_HOLD   0
`define PPH_SETUP_PWR       7
`define PPH_SETUP_CHAN_LSB  4
`define PPH_SETUP_STEP_LSB  0
`define PPH_MUTE_BIT        3
`define PPH_HS_EN           7
`define PPH_HS_STAT_LSB     5
`define PPH_HS_INS_LSB      2
`define PPH_HS_BTN_LSB      0

// ==========================================================
// Gain codes and timing
`define PPH_GAIN_MAX        8'h30
`define PPH_GAIN_MIN        8'h81
`define PPH_REF_HZ          1000000
`define PPH_REF_PER_MS      (`PPH_REF_HZ / 1000)
`define PPH_DB_SAMPLES      8

`endif

/* File: hdl/pph_ctrl.sv */
// Purpose: Playback path and headset control registers
// Assumes: Control bus front end issues one-cycle wr/rd strobes
// Notes:   Read data registered, valid one cycle after rd
//
// Functional notes
// - Two writable record-engine jump condition bits
// - Two writable playback-engine jump condition bits
// - Record counter cleared each frame unless held
// - Playback counter frame-clear selectable by bit
// - Power bit powers playback converter, reset down
// - Channel select: off, left, right, average
// - Soft-step per sample, per two, or off
// - Mute bit mutes playback, resets muted
// - Gain is signed half-dB, max +24 dB
// - Each code step adds half a decibel
// - Lowest gain -63.5 dB, code 0x80 reserved
// - Headset detection runs only when enabled
// - Read-only status: none, no mic, mic
// - Insertion debounce 16 to 512 ms
// - Button debounce none, 8, 16, 32 ms
// - Debounce timing from 1-MHz reference ticks
`timescale 1ns/10ps
`default_nettype none
`include "pph_cfg.svh"

module pph_ctrl (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Register access
   input  wire pph_pkg::pph_req_t   req,
   output logic [7:0]               rdata,
   // Timing strobes
   input  wire logic                ref_tick,
   input  wire logic                rec_frame_start,
   input  wire logic                play_frame_start,
   input  wire logic                play_sample_tick,
   // Audio
   input  wire pph_pkg::pph_stereo_t play_in,
   output logic signed [15:0]       play_out,
   output logic signed [7:0]        applied_gain,
   output logic                     play_muted,
   output logic                     dac_power_up,
   // Instruction engines
   output logic                     rec_aux_a,
   output logic                     rec_aux_b,
   output logic                     play_aux_a,
   output logic                     play_aux_b,
   output logic                     rec_ic_clear,
   output logic                     play_ic_clear,
   // Headset pins
   input  wire pph_pkg::pph_hs_t    hs_pin,
   input  wire logic                btn_pin,
   output logic [1:0]               hs_status,
   output logic                     btn_pressed
);

   // ==========================================================
   // Helper functions
   function automatic logic [7:0] fld_ins(input logic [7:0] v,
                                          input int lsb,
                                          input logic [1:0] f);
      logic [7:0] r;
      r = v;
      r[lsb +: 2] = f;
      return r;
   endfunction

   // Reserved codes fall back to the nearest legal code
   function automatic logic signed [7:0] gain_legal(
         input logic signed [7:0] g);
      logic signed [7:0] r;
      r = g;
      if (g > $signed(`PPH_GAIN_MAX))
         r = `PPH_GAIN_MAX;
      else if (g == 8'sh80)
         r = `PPH_GAIN_MIN;
      return r;
   endfunction

   // Milliseconds per insertion sample, eight samples per window
   function automatic logic [6:0] ins_ms(input logic [2:0] code);
      logic [6:0] r;
      case (code)
         3'h0:    r = 7'h02;
         3'h1:    r = 7'h04;
         3'h2:    r = 7'h08;
         3'h3:    r = 7'h10;
         3'h4:    r = 7'h20;
         default: r = 7'h40;
      endcase
      return r;
   endfunction

   function automatic logic [6:0] btn_ms(input logic [1:0] code);
      logic [6:0] r;
      case (code)
         2'h1:    r = 7'h01;
         2'h2:    r = 7'h02;
         default: r = 7'h04;
      endcase
      return r;
   endfunction

   // ==========================================================
   // Register storage
   logic [7:0] mode_q;
   logic [7:0] setup_q;
   logic [7:0] mute_q;
   logic [7:0] gain_q;
   logic [7:0] rsvd_q;
   logic [7:0] hsdet_q;
   logic [7:0] rdata_q;

   function automatic logic wr_hit(input logic [7:0] a);
      return req.wr && req.addr == a;
   endfunction

   always_ff @(posedge clk) begin
      if (rst)
         mode_q <= `PPH_RST_MODE;
      else if (wr_hit(`PPH_OFS_MODE))
         mode_q <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (rst)
         setup_q <= `PPH_RST_SETUP;
      else if (wr_hit(`PPH_OFS_SETUP))
         setup_q <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (rst)
         mute_q <= `PPH_RST_MUTE;
      else if (wr_hit(`PPH_OFS_MUTE))
         mute_q <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (rst)
         gain_q <= `PPH_RST_GAIN;
      else if (wr_hit(`PPH_OFS_GAIN))
         gain_q <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (rst)
         rsvd_q <= `PPH_RST_RSVD;
      else if (wr_hit(`PPH_OFS_RSVD))
         rsvd_q <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (rst)
         hsdet_q <= `PPH_RST_HSDET;
      else if (wr_hit(`PPH_OFS_HSDET))
         hsdet_q <= req.wdata;
   end

   // ==========================================================
   // Read port
   logic [1:0] hs_status_q;

   always_ff @(posedge clk) begin
      if (rst)
         rdata_q <= 8'h00;
      else if (req.rd) begin
         case (req.addr)
            `PPH_OFS_MODE:  rdata_q <= mode_q;
            `PPH_OFS_SETUP: rdata_q <= setup_q;
            `PPH_OFS_MUTE:  rdata_q <= mute_q;
            `PPH_OFS_GAIN:  rdata_q <= gain_q;
            `PPH_OFS_RSVD:  rdata_q <= rsvd_q;
            `PPH_OFS_HSDET:
               rdata_q <= fld_ins(hsdet_q, `PPH_HS_STAT_LSB, hs_status_q);
            default:        rdata_q <= 8'h00;
         endcase
      end
   end

   assign rdata = rdata_q;

   // ==========================================================
   // Instruction engine controls
   logic rec_clr_q;
   logic play_clr_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         rec_clr_q  <= 1'b0;
         play_clr_q <= 1'b0;
      end else begin
         rec_clr_q  <= rec_frame_start &&
                       !mode_q[`PPH_MODE_REC_HOLD];
         play_clr_q <= play_frame_start &&
                       !mode_q[`PPH_MODE_PLY_HOLD];
      end
   end

   assign rec_ic_clear  = rec_clr_q;
   assign play_ic_clear = play_clr_q;
   assign rec_aux_a     = mode_q[`PPH_MODE_REC_AUXA];
   assign rec_aux_b     = mode_q[`PPH_MODE_REC_AUXB];
   assign play_aux_a    = mode_q[`PPH_MODE_PLY_AUXA];
   assign play_aux_b    = mode_q[`PPH_MODE_PLY_AUXB];
   assign dac_power_up  = setup_q[`PPH_SETUP_PWR];

   // ==========================================================
   // Gain and mute
   logic              mute_bit;
   logic signed [7:0] gain_target;
   logic signed [7:0] gain_cur;
   logic              muted_q;

   assign mute_bit    = mute_q[`PPH_MUTE_BIT];
   // Mute ramps down to the floor so it obeys soft-stepping too
   assign gain_target = mute_bit ? $signed(`PPH_GAIN_MIN)
                                 : gain_legal($signed(gain_q));

   pph_gain_step u_step (
      .clk         (clk),
      .rst         (rst),
      .sample_tick (play_sample_tick),
      .mode        (setup_q[`PPH_SETUP_STEP_LSB +: 2]),
      .target      (gain_target),
      .current     (gain_cur)
   );

   // Stays muted out of reset; a fresh mute waits for the gain floor
   always_ff @(posedge clk) begin
      if (rst)
         muted_q <= 1'b1;
      else if (!mute_bit)
         muted_q <= 1'b0;
      else if (gain_cur == $signed(`PPH_GAIN_MIN))
         muted_q <= 1'b1;
   end

   assign applied_gain = gain_cur;
   assign play_muted   = muted_q;

   // ==========================================================
   // Channel selection
   logic signed [15:0] out_q;
   logic signed [16:0] lr_sum;
   pph_pkg::pph_chan_t chan;

   assign lr_sum = {play_in.left[15], play_in.left} +
                   {play_in.right[15], play_in.right};
   assign chan   = pph_pkg::pph_chan_t'(setup_q[`PPH_SETUP_CHAN_LSB +: 2]);

   always_ff @(posedge clk) begin
      if (rst)
         out_q <= 16'sh0000;
      else if (play_sample_tick) begin
         if (!dac_power_up || muted_q)
            out_q <= 16'sh0000;
         else begin
            case (chan)
               pph_pkg::PPH_CH_LEFT:  out_q <= play_in.left;
               pph_pkg::PPH_CH_RIGHT: out_q <= play_in.right;
               pph_pkg::PPH_CH_AVG:   out_q <= lr_sum[16:1];
               default:               out_q <= 16'sh0000;
            endcase
         end
      end
   end

   assign play_out = out_q;

   // ==========================================================
   // Headset pin synchronisers
   pph_pkg::pph_hs_t hs_s1_q;
   pph_pkg::pph_hs_t hs_s2_q;
   logic             btn_s1_q;
   logic             btn_s2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         hs_s1_q  <= '0;
         hs_s2_q  <= '0;
         btn_s1_q <= 1'b0;
         btn_s2_q <= 1'b0;
      end else begin
         hs_s1_q  <= hs_pin;
         hs_s2_q  <= hs_s1_q;
         btn_s1_q <= btn_pin;
         btn_s2_q <= btn_s1_q;
      end
   end

   // ==========================================================
   // Headset debounce and status
   logic       hs_en;
   logic [1:0] ins_stable;
   logic       btn_stable;
   logic       btn_q;

   assign hs_en = hsdet_q[`PPH_HS_EN];

   pph_debounce #(.W(2)) u_ins_db (
      .clk       (clk),
      .rst       (rst),
      .en        (hs_en),
      .bypass    (1'b0),
      .period_ms (ins_ms(hsdet_q[`PPH_HS_INS_LSB +: 3])),
      .ref_tick  (ref_tick),
      .raw       ({hs_s2_q.present, hs_s2_q.mic}),
      .stable    (ins_stable)
   );

   pph_debounce #(.W(1)) u_btn_db (
      .clk       (clk),
      .rst       (rst),
      .en        (hs_en),
      .bypass    (hsdet_q[`PPH_HS_BTN_LSB +: 2] == 2'h0),
      .period_ms (btn_ms(hsdet_q[`PPH_HS_BTN_LSB +: 2])),
      .ref_tick  (ref_tick),
      .raw       (btn_s2_q),
      .stable    (btn_stable)
   );

   // Mic without plug is not a legal state, so 10 never shows
   always_ff @(posedge clk) begin
      if (rst || !hs_en)
         hs_status_q <= 2'h0;
      else if (!ins_stable[1])
         hs_status_q <= 2'h0;
      else
         hs_status_q <= ins_stable[0] ? 2'h3 : 2'h1;
   end

   always_ff @(posedge clk) begin
      if (rst)
         btn_q <= 1'b0;
      else
         btn_q <= hs_en && btn_stable && hs_status_q == 2'h3;
   end

   assign hs_status   = hs_status_q;
   assign btn_pressed = btn_q;

endmodule
`default_nettype wire

/* File: hdl/pph_debounce.sv */
// Purpose: Glitch filter clocked by 1-MHz reference ticks
// Assumes: raw already synchronised; ref_tick is a one-cycle pulse
// Notes:   Output follows raw after eight equal samples
`timescale 1ns/10ps
`default_nettype none
`include "pph_cfg.svh"

module pph_debounce #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control
   input  wire logic         en,
   input  wire logic         bypass,
   input  wire logic [6:0]   period_ms,
   input  wire logic         ref_tick,
   // Data
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] stable
);

   logic [9:0]   us_cnt_q;
   logic [6:0]   ms_cnt_q;
   logic [3:0]   same_q;
   logic [W-1:0] cand_q;
   logic [W-1:0] stable_q;
   logic         ms_tick;
   logic         samp_tick;

   assign ms_tick   = ref_tick && (us_cnt_q == 10'(`PPH_REF_PER_MS - 1));
   // At-or-past compare: a shorter period set mid-count must not wrap
   assign samp_tick = ms_tick && (ms_cnt_q >= 7'(period_ms - 7'h01));
   assign stable    = stable_q;

   always_ff @(posedge clk) begin
      if (rst || !en)
         us_cnt_q <= 10'h000;
      else if (ms_tick)
         us_cnt_q <= 10'h000;
      else if (ref_tick)
         us_cnt_q <= us_cnt_q + 10'h001;
   end

   always_ff @(posedge clk) begin
      if (rst || !en)
         ms_cnt_q <= 7'h00;
      else if (samp_tick)
         ms_cnt_q <= 7'h00;
      else if (ms_tick)
         ms_cnt_q <= ms_cnt_q + 7'h01;
   end

   // Cleared while disabled so a re-enable starts from nothing
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         cand_q   <= '0;
         same_q   <= 4'h0;
         stable_q <= '0;
      end else if (bypass) begin
         stable_q <= raw;
         cand_q   <= raw;
      end else if (samp_tick) begin
         if (raw != cand_q) begin
            cand_q <= raw;
            same_q <= 4'h1;
         end else if (same_q >= 4'(`PPH_DB_SAMPLES - 1)) begin
            stable_q <= cand_q;
         end else begin
            same_q <= same_q + 4'h1;
         end
      end
   end

endmodule
`default_nettype wire

/* File: hdl/pph_gain_step.sv */
// Purpose: Soft-stepping of the applied playback gain code
// Assumes: sample_tick pulses once per playback sample period
// Notes:   One half-decibel step per qualified tick
`timescale 1ns/10ps
`default_nettype none

module pph_gain_step (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Control
   input  wire logic              sample_tick,
   input  wire logic [1:0]        mode,
   input  wire logic signed [7:0] target,
   // Applied gain
   output logic signed [7:0]      current
);

   logic              phase_q;
   logic signed [7:0] cur_q;
   logic              step_ok;

   assign current = cur_q;
   assign step_ok = (mode == 2'h0) || (mode == 2'h1 && phase_q);

   always_ff @(posedge clk) begin
      if (rst)
         phase_q <= 1'b0;
      else if (sample_tick)
         phase_q <= ~phase_q;
   end

   always_ff @(posedge clk) begin
      if (rst)
         cur_q <= 8'sh00;
      else if (sample_tick) begin
         if (mode[1])
            cur_q <= target;
         else if (step_ok && cur_q < target)
            cur_q <= cur_q + 8'sh01;
         else if (step_ok && cur_q > target)
            cur_q <= cur_q - 8'sh01;
      end
   end

endmodule
`default_nettype wire

/* File: hdl/pph_pkg.sv */
// Purpose: Shared types of the playback path and headset control
// Assumes: Constants come from pph_cfg.svh
// Notes:   Types only
package pph_pkg;

   // ==========================================================
   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pph_req_t;

   // ==========================================================
   // Headset comparator levels
   typedef struct packed {
      logic present;
      logic mic;
   } pph_hs_t;

   // ==========================================================
   // Stereo input sample
   typedef struct packed {
      logic signed [15:0] left;
      logic signed [15:0] right;
   } pph_stereo_t;

   typedef enum logic [1:0] {
      PPH_CH_OFF   = 2'h0,
      PPH_CH_LEFT  = 2'h1,
      PPH_CH_RIGHT = 2'h2,
      PPH_CH_AVG   = 2'h3
   } pph_chan_t;

endpackage
